/* common/udt_pkg.sv */
// Summary of operation
// R01: Two cascaded count bytes form 16-bit counter.
// R02: Select bit picks divide-by-12 or pin edges.
// R03: Counter advances only while run bit set.
// R04: Serial and capture bits choose three modes.
// R05: Up/down enable lets direction pin steer counting.
// R06: Up overflow sets flag, reloads from reload pair.
// R07: Down match with reload sets flag, loads FFFFh.
// R08: Up/down wraps toggle external flag, no interrupt.
// R09: Clock-out mode counts at peripheral clock / 2.
// R10: Clock-out overflows reload and raise no interrupt.
// R11: Pin clock is clk / (4 x (65536 - reload)).
// R12: Software sequence to start clock-out output.
// R13: Baud and clock-out share one reload pair.
// R14: Overflow flag only without serial selects; software clears.
// R15: Direction pin fall captures or reloads, sets flag.
// R16: Serial select forces auto-reload, overflow clocks serial.
// R17: Output enable turns count pin into clock output.
// R18: Clock-out pin toggles on every overflow.
package udt_pkg;

  localparam logic [7:0]  UDT_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  UDT_MODE_OFS   = 8'h04;
  localparam logic [7:0]  UDT_COUNT_OFS  = 8'h08;
  localparam logic [7:0]  UDT_RELOAD_OFS = 8'h0c;
  localparam logic [7:0]  UDT_STAT_OFS   = 8'h10;
  localparam logic [7:0]  UDT_MASK_OFS   = 8'h14;

  localparam int          UDT_CTRL_OVF   = 7;
  localparam int          UDT_CTRL_EXT   = 6;
  localparam int          UDT_CTRL_RXC   = 5;
  localparam int          UDT_CTRL_TXC   = 4;
  localparam int          UDT_CTRL_EXEN  = 3;
  localparam int          UDT_CTRL_RUN   = 2;
  localparam int          UDT_CTRL_CTS   = 1;
  localparam int          UDT_CTRL_CAP   = 0;
  localparam int          UDT_MODE_OE    = 1;
  localparam int          UDT_MODE_UD    = 0;

  localparam int          UDT_IRQ_W      = 3;
  localparam int          UDT_IRQ_OVF    = 0;
  localparam int          UDT_IRQ_EXT    = 1;
  localparam int          UDT_IRQ_SER    = 2;

  localparam logic [7:0]  UDT_CTRL_RST   = 8'h00;
  localparam logic [1:0]  UDT_MODE_RST   = 2'h0;
  localparam logic [15:0] UDT_COUNT_RST  = 16'h0000;
  localparam logic [15:0] UDT_RELOAD_RST = 16'h0000;
  localparam logic [2:0]  UDT_MASK_RST   = 3'h0;

  localparam logic [15:0] UDT_COUNT_MAX  = 16'hffff;
  localparam logic [3:0]  UDT_TIMER_DIV  = 4'hc;
  localparam logic [3:0]  UDT_CLKOUT_DIV = 4'h2;

  typedef enum logic {UDT_APB_IDLE, UDT_APB_ACCESS} udt_apb_state_t;

endpackage

/* hdl/udt_prescaler.sv */
`timescale 1ns/1ps
module udt_prescaler
  import udt_pkg::*;
#(
  parameter int DIV_W = 4
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             enable,
  input  wire logic [DIV_W-1:0] divide,
  output logic                  tick
);

  logic [DIV_W-1:0] cnt_reg;

  // Restarts whenever disabled so the first tick after run is a full period;
  // a low clock enable only freezes it, so a paused timer keeps its phase
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (ce)
    begin
      if (!enable || (cnt_reg >= divide - DIV_W'(1)))
        cnt_reg <= '0;
      else
        cnt_reg <= cnt_reg + DIV_W'(1);
    end
  end

  assign tick = ce && enable && (cnt_reg >= divide - DIV_W'(1));

endmodule

/* hdl/udt_fall_detect.sv */
`timescale 1ns/1ps
module udt_fall_detect
#(
  parameter int W = 2
)
(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] sig,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk_sys)
      begin
        if (rst)
          prev_reg[i] <= 1'b0;
        else if (ce)
          prev_reg[i] <= sig[i];
      end
      assign fall[i] = prev_reg[i] & ~sig[i];
    end
  endgenerate

endmodule

/* hdl/udt_timer.sv */
`timescale 1ns/1ps
module udt_timer
  import udt_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              count_pin_i,
  output logic                   count_pin_o,
  output logic                   count_pin_oe,
  input  wire logic              dir_pin_i,
  output logic                   serial_clk_tick,
  output logic                   timer_irq,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  udt_apb_state_t       apb_state_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic [31:0]          prdata_reg;
  logic [31:0]          rdata;
  logic                 hit;
  logic [7:0]           ctrl_reg;
  logic [1:0]           mode_reg;
  logic [7:0]           count_low_byte_reg;
  logic [7:0]           count_high_byte_reg;
  logic [7:0]           reload_low_byte_reg;
  logic [7:0]           reload_high_byte_reg;
  logic [UDT_IRQ_W-1:0] stat_reg;
  logic [UDT_IRQ_W-1:0] stat_next;
  logic [UDT_IRQ_W-1:0] stat_snap_reg;
  logic [UDT_IRQ_W-1:0] mask_reg;
  logic [UDT_IRQ_W-1:0] events;
  logic                 irq_reg;
  logic                 timer_irq_reg;
  logic                 count_pin_o_reg;
  logic                 count_pin_oe_reg;
  logic                 serial_tick_reg;
  logic                 access;
  logic                 wr_acc;
  logic                 rd_acc;
  logic                 wr_ctrl;
  logic                 wr_mode;
  logic                 wr_count;
  logic                 wr_reload;
  logic                 wr_mask;
  logic                 rd_stat;

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign irq             = irq_reg;
  assign timer_irq       = timer_irq_reg;
  assign count_pin_o     = count_pin_o_reg;
  assign count_pin_oe    = count_pin_oe_reg;
  assign serial_clk_tick = serial_tick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, pready rises on the access cycle

  assign access    = ce && psel && penable && pready_reg;
  assign wr_acc    = access && pwrite;
  assign rd_acc    = access && !pwrite;
  assign wr_ctrl   = wr_acc && (paddr == ADDR_W'(UDT_CTRL_OFS));
  assign wr_mode   = wr_acc && (paddr == ADDR_W'(UDT_MODE_OFS));
  assign wr_count  = wr_acc && (paddr == ADDR_W'(UDT_COUNT_OFS));
  assign wr_reload = wr_acc && (paddr == ADDR_W'(UDT_RELOAD_OFS));
  assign wr_mask   = wr_acc && (paddr == ADDR_W'(UDT_MASK_OFS));
  assign rd_stat   = rd_acc && (paddr == ADDR_W'(UDT_STAT_OFS));

  always_comb
  begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    if (paddr == ADDR_W'(UDT_CTRL_OFS))
      rdata = {24'h00_0000, ctrl_reg};
    else if (paddr == ADDR_W'(UDT_MODE_OFS))
      rdata = {30'h0000_0000, mode_reg};
    else if (paddr == ADDR_W'(UDT_COUNT_OFS))
      rdata = {16'h0000, count_high_byte_reg, count_low_byte_reg};
    else if (paddr == ADDR_W'(UDT_RELOAD_OFS))
      rdata = {16'h0000, reload_high_byte_reg, reload_low_byte_reg};
    else if (paddr == ADDR_W'(UDT_STAT_OFS))
      rdata = {29'h0000_0000, stat_reg};
    else if (paddr == ADDR_W'(UDT_MASK_OFS))
      rdata = {29'h0000_0000, mask_reg};
    else
      hit = 1'b0;
  end

  // Read data and the status snapshot are taken in the setup cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      apb_state_reg <= UDT_APB_IDLE;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      prdata_reg    <= 32'h0000_0000;
      stat_snap_reg <= '0;
    end
    else if (ce)
    begin
      case (apb_state_reg)
        UDT_APB_IDLE:
        begin
          if (psel && !penable)
          begin
            apb_state_reg <= UDT_APB_ACCESS;
            pready_reg    <= 1'b1;
            pslverr_reg   <= !hit;
            prdata_reg    <= pwrite ? 32'h0000_0000 : rdata;
            stat_snap_reg <= stat_reg;
          end
        end
        default:
        begin
          apb_state_reg <= UDT_APB_IDLE;
          pready_reg    <= 1'b0;
          pslverr_reg   <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  logic        serial_mode;
  logic        clkout_mode;
  logic        updown_mode;
  logic        autoreload;
  logic        count_up;
  logic        run;
  logic        presc_tick;
  logic [1:0]  falls;
  logic        step;
  logic [15:0] count_val;
  logic [15:0] reload_val;
  logic        wrap_up;
  logic        wrap_down;
  logic        wrap;
  logic        trig;
  logic        ovf_set;

  assign serial_mode = ctrl_reg[UDT_CTRL_RXC] | ctrl_reg[UDT_CTRL_TXC];
  assign clkout_mode = mode_reg[UDT_MODE_OE] & ~ctrl_reg[UDT_CTRL_CTS];
  assign autoreload  = serial_mode | ~ctrl_reg[UDT_CTRL_CAP];                   // R16 R04
  assign updown_mode = mode_reg[UDT_MODE_UD] & autoreload & ~serial_mode;
  assign count_up    = ~updown_mode | dir_pin_i;                                // R05
  assign run         = ctrl_reg[UDT_CTRL_RUN];
  assign count_val   = {count_high_byte_reg, count_low_byte_reg};
  assign reload_val  = {reload_high_byte_reg, reload_low_byte_reg};

  udt_prescaler #(
    .DIV_W   (4)
  ) u_presc (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .enable  (run && !ctrl_reg[UDT_CTRL_CTS]),
    .divide  (clkout_mode ? UDT_CLKOUT_DIV : UDT_TIMER_DIV),                    // R02 R09
    .tick    (presc_tick)
  );

  udt_fall_detect #(
    .W       (2)
  ) u_fall (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .sig     ({dir_pin_i, count_pin_i}),
    .fall    (falls)
  );

  // An enabled output pin is never counted as its own input
  assign step = ce && run &&                                                    // R03
                (ctrl_reg[UDT_CTRL_CTS] ? (falls[0] & ~mode_reg[UDT_MODE_OE]) : presc_tick); // R02
  assign wrap_up   = step && count_up && (count_val == UDT_COUNT_MAX);
  assign wrap_down = step && !count_up && (count_val == reload_val);
  assign wrap      = wrap_up || wrap_down;
  // Direction pin is the count direction in up/down mode, so it triggers nothing
  assign trig      = ce && ctrl_reg[UDT_CTRL_EXEN] && !serial_mode && !updown_mode && falls[1]; // R15
  assign ovf_set   = wrap && !serial_mode && !clkout_mode;                      // R14 R10

  ////////////////////////////////////////////////////////////////////////////
  // Control and mode registers; hardware set beats a software clear

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      ctrl_reg <= UDT_CTRL_RST;
    else if (ce)
    begin
      if (wr_ctrl)
        ctrl_reg <= pwdata[7:0];
      if (ovf_set)
        ctrl_reg[UDT_CTRL_OVF] <= 1'b1;                                         // R14 R06 R07
      if (trig)
        ctrl_reg[UDT_CTRL_EXT] <= 1'b1;                                         // R15
      else if (updown_mode && wrap)
        ctrl_reg[UDT_CTRL_EXT] <= ~ctrl_reg[UDT_CTRL_EXT];                      // R08
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      mode_reg <= UDT_MODE_RST;
    else if (wr_mode)
      mode_reg <= pwdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter: low byte carries or borrows into the high byte

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count_low_byte_reg  <= UDT_COUNT_RST[7:0];
      count_high_byte_reg <= UDT_COUNT_RST[15:8];
    end
    else if (wr_count)
    begin
      count_low_byte_reg  <= pwdata[7:0];
      count_high_byte_reg <= pwdata[15:8];
    end
    else if (trig && !ctrl_reg[UDT_CTRL_CAP])
    begin
      count_low_byte_reg  <= reload_low_byte_reg;                               // R15
      count_high_byte_reg <= reload_high_byte_reg;
    end
    else if (wrap_up)
    begin
      // Capture mode wraps freely; every other mode reloads
      count_low_byte_reg  <= autoreload ? reload_low_byte_reg : 8'h00;          // R06 R10 R13
      count_high_byte_reg <= autoreload ? reload_high_byte_reg : 8'h00;
    end
    else if (wrap_down)
    begin
      count_low_byte_reg  <= UDT_COUNT_MAX[7:0];                                // R07
      count_high_byte_reg <= UDT_COUNT_MAX[15:8];
    end
    else if (step)
    begin
      if (count_up)
      begin
        count_low_byte_reg <= count_low_byte_reg + 8'h01;                       // R01
        if (count_low_byte_reg == 8'hff)
          count_high_byte_reg <= count_high_byte_reg + 8'h01;
      end
      else
      begin
        count_low_byte_reg <= count_low_byte_reg - 8'h01;
        if (count_low_byte_reg == 8'h00)
          count_high_byte_reg <= count_high_byte_reg - 8'h01;
      end
    end
  end

  // One reload pair serves capture, auto-reload, baud and clock-out alike
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reload_low_byte_reg  <= UDT_RELOAD_RST[7:0];
      reload_high_byte_reg <= UDT_RELOAD_RST[15:8];
    end
    else if (wr_reload)
    begin
      reload_low_byte_reg  <= pwdata[7:0];
      reload_high_byte_reg <= pwdata[15:8];
    end
    else if (trig && ctrl_reg[UDT_CTRL_CAP])
    begin
      reload_low_byte_reg  <= count_low_byte_reg;                               // R15
      reload_high_byte_reg <= count_high_byte_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and serial outputs

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count_pin_o_reg  <= 1'b0;
      count_pin_oe_reg <= 1'b0;
      serial_tick_reg  <= 1'b0;
    end
    else if (ce)
    begin
      count_pin_oe_reg <= mode_reg[UDT_MODE_OE];                                // R17
      serial_tick_reg  <= wrap && serial_mode;                                  // R16
      if (clkout_mode && wrap)
        count_pin_o_reg <= ~count_pin_o_reg;                                    // R18 R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: only bits already returned by the read are cleared

  assign events[UDT_IRQ_OVF] = ovf_set;
  assign events[UDT_IRQ_EXT] = trig;
  assign events[UDT_IRQ_SER] = wrap && serial_mode;
  assign stat_next = (stat_reg & ~(rd_stat ? stat_snap_reg : '0)) | (ce ? events : '0);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      stat_reg      <= '0;
      mask_reg      <= UDT_MASK_RST;
      irq_reg       <= 1'b0;
      timer_irq_reg <= 1'b0;
    end
    else if (ce)
    begin
      stat_reg <= stat_next;
      if (wr_mask)
        mask_reg <= pwdata[UDT_IRQ_W-1:0];
      irq_reg       <= |(stat_next & (wr_mask ? pwdata[UDT_IRQ_W-1:0] : mask_reg));
      // External flag raises no request in up/down mode
      timer_irq_reg <= ctrl_reg[UDT_CTRL_OVF] | (ctrl_reg[UDT_CTRL_EXT] & ~mode_reg[UDT_MODE_UD]); // R08
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  run_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // R03
    ce && !run && !wr_count && !trig |=> $stable(count_val))
    else $error("counter moved while stopped");

  up_reload_a: assert property (@(posedge clk_sys) disable iff (rst) // R06
    wrap_up && autoreload && !wr_count && !trig |=> count_val == $past(reload_val))
    else $error("overflow did not reload");

  down_max_a: assert property (@(posedge clk_sys) disable iff (rst) // R07
    wrap_down && !wr_count && !trig |=> count_val == 16'hffff)
    else $error("underflow did not load ffff");

  ovf_flag_a: assert property (@(posedge clk_sys) disable iff (rst) // R14
    ce && wrap && !serial_mode && !clkout_mode |=> ctrl_reg[UDT_CTRL_OVF] ##1 timer_irq)
    else $error("overflow flag or request missing");

  serial_noflag_a: assert property (@(posedge clk_sys) disable iff (rst) // R14
    ce && serial_mode && !ctrl_reg[UDT_CTRL_OVF] && !wr_ctrl |=> !ctrl_reg[UDT_CTRL_OVF])
    else $error("overflow flag set in serial mode");

  ext_toggle_a: assert property (@(posedge clk_sys) disable iff (rst) // R08
    updown_mode && wrap && !wr_ctrl |=> ctrl_reg[UDT_CTRL_EXT] != $past(ctrl_reg[UDT_CTRL_EXT]))
    else $error("external flag did not toggle");

  clk_toggle_a: assert property (@(posedge clk_sys) disable iff (rst) // R18
    ce && clkout_mode && wrap |=> count_pin_o != $past(count_pin_o))
    else $error("clock pin did not toggle");

  byte_carry_a: assert property (@(posedge clk_sys) disable iff (rst) // R01
    step && count_up && !wrap && count_low_byte_reg == 8'hff && !wr_count && !trig
    |=> count_high_byte_reg == $past(count_high_byte_reg) + 8'h01 && count_low_byte_reg == 8'h00)
    else $error("low byte carry lost");

  capture_a: assert property (@(posedge clk_sys) disable iff (rst) // R15
    trig && ctrl_reg[UDT_CTRL_CAP] && !wr_reload |=> reload_val == $past(count_val))
    else $error("capture missed");

  pin_enable_a: assert property (@(posedge clk_sys) disable iff (rst) // R17
    ce && mode_reg[UDT_MODE_OE] |=> count_pin_oe)
    else $error("clock output not enabled");

endmodule

/* bench/udt_pin_model.sv */
`timescale 1ns/1ps
module udt_pin_model
(
  input  wire logic clk_sys,
  input  wire logic count_pin_o,
  input  wire logic count_pin_oe,
  output logic      count_pin_i,
  output logic      dir_pin_i
);
  logic drv_q;

  initial
  begin
    drv_q = 1'b1;
    dir_pin_i = 1'b1;
  end

  // Pulled-up pin; the timer's own drive wins while its enable is up
  assign count_pin_i = count_pin_oe ? count_pin_o : drv_q;

  // Low and high long enough for the edge detector to see each level
  task pulse();
    @(posedge clk_sys);
    drv_q <= 1'b0;
    repeat (3) @(posedge clk_sys);
    drv_q <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  task set_dir(input logic v);
    @(posedge clk_sys);
    dir_pin_i <= v;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import udt_pkg::*;
  logic        clk_sys;
  logic        rst;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        count_pin_i;
  logic        count_pin_o;
  logic        count_pin_oe;
  logic        dir_pin_i;
  logic        serial_clk_tick;
  logic        timer_irq;
  logic        irq;
  logic [31:0] rd_q;
  logic        err_q;
  int          bad_count;
  int          total_checks;
  int          rises;
  int          ser_n;
  int          n0;
  int          k;
  longint      rise_last;
  longint      rise_prev;

  udt_timer DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_pin_i(count_pin_i), .count_pin_o(count_pin_o),
    .count_pin_oe(count_pin_oe), .dir_pin_i(dir_pin_i), .serial_clk_tick(serial_clk_tick),
    .timer_irq(timer_irq), .irq(irq));
  udt_pin_model pins (.clk_sys(clk_sys), .count_pin_o(count_pin_o), .count_pin_oe(count_pin_oe),
    .count_pin_i(count_pin_i), .dir_pin_i(dir_pin_i));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge count_pin_o)
  begin
    rise_prev = rise_last;
    rise_last = $time;
    rises++;
  end

  always @(posedge clk_sys)
    if (serial_clk_tick === 1'b1)
      ser_n++;

  ////////////////////////////////////////////////////////////////////////////////
  task summarize();
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; returns one edge after release
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge clk_sys);
    end
    if (n >= 20)
    begin
      bad_count++;
      summarize();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd_q, exp);
  endtask

  task wait_edges(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    total_checks = 0;
    rises = 0;
    ser_n = 0;
    rise_last = 0;
    rise_prev = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdc(UDT_CTRL_OFS, 32'h0);
    rdc(UDT_COUNT_OFS, 32'(UDT_COUNT_RST));
    rdc(UDT_RELOAD_OFS, 32'(UDT_RELOAD_RST));
    apb(1'b0, 8'h20, 32'h0);
    check(32'(err_q), 32'h1);
    check(rd_q, 32'h0);
    // Divided clock: ten ticks of twelve within the run window
    wr(UDT_COUNT_OFS, 32'h0);
    wr(UDT_CTRL_OFS, 32'h04);
    wait_edges(122);
    wr(UDT_CTRL_OFS, 32'h00);
    rdc(UDT_COUNT_OFS, 32'd10);
    // Clock enable low for longer than a tick period must freeze the counter
    wr(UDT_COUNT_OFS, 32'h0);
    wr(UDT_CTRL_OFS, 32'h04);
    ce <= 1'b0;
    wait_edges(200);
    ce <= 1'b1;
    wr(UDT_CTRL_OFS, 32'h00);
    rdc(UDT_COUNT_OFS, 32'h0);
    // Up overflow reloads, flags and interrupts
    wr(UDT_MASK_OFS, 32'h7);
    rdc(UDT_MASK_OFS, 32'h7);
    wr(UDT_RELOAD_OFS, 32'h1234);
    wr(UDT_COUNT_OFS, 32'hffff);
    wr(UDT_CTRL_OFS, 32'h04);
    wait_edges(14);
    wr(UDT_CTRL_OFS, 32'h80);
    rdc(UDT_COUNT_OFS, 32'h1234);
    rdc(UDT_CTRL_OFS, 32'h80);
    check(32'(timer_irq), 32'h1);
    check(32'(irq), 32'h1);
    wait_edges(30);
    rdc(UDT_COUNT_OFS, 32'h1234);
    rdc(UDT_STAT_OFS, 32'h1);
    check(32'(irq), 32'h0);
    wr(UDT_CTRL_OFS, 32'h00);
    rdc(UDT_CTRL_OFS, 32'h00);
    // Pin counting counts up with up/down off, whatever the direction pin says
    pins.set_dir(1'b0);
    wr(UDT_COUNT_OFS, 32'h0);
    wr(UDT_CTRL_OFS, 32'h06);
    for (k = 0; k < 5; k++)
      pins.pulse();
    rdc(UDT_COUNT_OFS, 32'd5);
    // Low byte rollover must carry into the high byte
    wr(UDT_COUNT_OFS, 32'h00ff);
    pins.pulse();
    rdc(UDT_COUNT_OFS, 32'h0100);
    wr(UDT_CTRL_OFS, 32'h02);
    pins.pulse();
    rdc(UDT_COUNT_OFS, 32'h0100);
    // Up/down: match with reload underflows, wrap toggles the extra bit
    wr(UDT_MODE_OFS, 32'h1);
    wr(UDT_RELOAD_OFS, 32'h0010);
    wr(UDT_COUNT_OFS, 32'h0011);
    wr(UDT_CTRL_OFS, 32'h06);
    pins.pulse();
    rdc(UDT_COUNT_OFS, 32'h0010);
    pins.pulse();
    rdc(UDT_COUNT_OFS, 32'(UDT_COUNT_MAX));
    rdc(UDT_CTRL_OFS, 32'hc6);
    pins.set_dir(1'b1);
    pins.pulse();
    rdc(UDT_COUNT_OFS, 32'h0010);
    rdc(UDT_CTRL_OFS, 32'h86);
    rdc(UDT_STAT_OFS, 32'h1);
    // Direction pin fall: capture, then reload
    wr(UDT_CTRL_OFS, 32'h00);
    wr(UDT_MODE_OFS, 32'h0);
    wr(UDT_COUNT_OFS, 32'habcd);
    wr(UDT_CTRL_OFS, 32'h09);
    pins.set_dir(1'b0);
    rdc(UDT_RELOAD_OFS, 32'habcd);
    rdc(UDT_CTRL_OFS, 32'h49);
    rdc(UDT_STAT_OFS, 32'h2);
    wr(UDT_RELOAD_OFS, 32'h5555);
    wr(UDT_CTRL_OFS, 32'h08);
    pins.set_dir(1'b1);
    pins.set_dir(1'b0);
    rdc(UDT_COUNT_OFS, 32'h5555);
    rdc(UDT_STAT_OFS, 32'h2);
    // Serial select forces reload despite capture select
    wr(UDT_CTRL_OFS, 32'h00);
    wr(UDT_RELOAD_OFS, 32'h0100);
    wr(UDT_COUNT_OFS, 32'hffff);
    n0 = ser_n;
    wr(UDT_CTRL_OFS, 32'h15);
    for (k = 0; k < 40 && ser_n == n0; k++)
      @(posedge clk_sys);
    check(32'(ser_n - n0), 32'h1);
    wr(UDT_CTRL_OFS, 32'h11);
    rdc(UDT_COUNT_OFS, 32'h0100);
    rdc(UDT_CTRL_OFS, 32'h11);
    rdc(UDT_STAT_OFS, 32'h4);
    // Clock-out, programmed in the documented order
    wr(UDT_CTRL_OFS, 32'h00);
    check(32'(count_pin_oe), 32'h0);
    wr(UDT_MODE_OFS, 32'h2);
    wr(UDT_CTRL_OFS, 32'h00);
    wr(UDT_RELOAD_OFS, 32'hfffe);
    wr(UDT_COUNT_OFS, 32'hfffe);
    wr(UDT_CTRL_OFS, 32'h04);
    n0 = rises;
    for (k = 0; k < 100 && rises < n0 + 3; k++)
      @(posedge clk_sys);
    if (rises < n0 + 3)
    begin
      bad_count++;
      summarize();
    end
    check(32'(rise_last - rise_prev), 32'(4 * (65536 - 32'hfffe) * 10));
    check(32'(count_pin_oe), 32'h1);
    check(32'(count_pin_i), 32'(count_pin_o));
    rdc(UDT_CTRL_OFS, 32'h04);
    rdc(UDT_STAT_OFS, 32'h0);
    summarize();
  end
endmodule
